// *** hdl/stw_divider.sv ***
`timescale 1ns/10ps
// programmable divider: one-cycle tick every (div+1) enabled cycles
module stw_divider #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// control
	input wire logic en_i,
	input wire logic [W-1:0] div_i,
	// tick
	output logic tick_o
);
	if (W < 1 || W > 16) begin : g_bad_width
		$error("stw_divider: width out of range");
	end

	logic [W-1:0] cnt_r;
	wire logic at_end = (cnt_r >= div_i);

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			cnt_r <= '0;
		end else if (en_i) begin
			cnt_r <= at_end ? '0 : cnt_r + W'(1);
		end
	end

	assign tick_o = en_i && at_end;

	property p_tick_spacing;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		tick_o |=> !tick_o || (div_i == '0);
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("divider ticked twice in a row with nonzero divisor");
endmodule : stw_divider

// *** hdl/stw_timer.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - load select is bit 7 of ms interrupt register, always reads zero
// - write with select 0 holds value, loads it at next expiry
// - write with select 1 loads the counter right after the write
// - ms interrupt every (count+1) ms ticks
// - reading the ms interrupt register clears the pending flag
// - microsecond tick divides system clock by divisor plus one
// - microsecond tick is the flash write time base
// - ms tick period is high*256+low+1 system clocks
// - ms tick is the flash erase time base
// - 100 ms tick divides ms tick by divisor plus one
// - write 1 then 0 to enable bit turns watchdog on; reads state
// - write 1 then 0 to disable bit turns watchdog off; reads state
// - write 1 then 0 to restart bit restarts watchdog; reads last written value
// - watchdog expires within count+1 to count+2 hundred-ms periods
// - power-down inputs stop watchdog and system timer
////////////////////////////////////////////////////////////////////////////////
module stw_timer (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// special function register bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_sel_o,
	// power-down controls
	input wire logic watchdog_power_down_i,
	input wire logic system_timer_power_down_i,
	// ticks and events
	output logic us_tick_o,
	output logic ms_tick_o,
	output logic hms_tick_o,
	output logic ms_int_o,
	output logic watchdog_expired_o
);
	localparam int CW = stw_pkg::MS_CNT_W;
	localparam int WW = stw_pkg::WD_PERIOD_W;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// address decode
	wire logic sel_ms = hit(sfr_addr_i, stw_pkg::ADDR_MS_INT);
	wire logic sel_us = hit(sfr_addr_i, stw_pkg::ADDR_US_DIV);
	wire logic sel_ml = hit(sfr_addr_i, stw_pkg::ADDR_MS_DIV_LO);
	wire logic sel_mh = hit(sfr_addr_i, stw_pkg::ADDR_MS_DIV_HI);
	wire logic sel_hm = hit(sfr_addr_i, stw_pkg::ADDR_HMS_DIV);
	wire logic sel_wd = hit(sfr_addr_i, stw_pkg::ADDR_WDT);
	wire logic wr_ms = sfr_wr_i && sel_ms;
	wire logic wr_wd = sfr_wr_i && sel_wd;
	wire logic rd_ms = sfr_rd_i && sel_ms;

	////////////////////////////////////////////////////////////////////////////
	// divisor registers
	logic [stw_pkg::US_DIV_W-1:0] us_div_r;
	logic [7:0] ms_lo_r;
	logic [7:0] ms_hi_r;
	logic [7:0] hms_div_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			us_div_r <= stw_pkg::RST_US_DIV;
			ms_lo_r <= stw_pkg::RST_MS_DIV_LO;
			ms_hi_r <= stw_pkg::RST_MS_DIV_HI;
			hms_div_r <= stw_pkg::RST_HMS_DIV;
		end else if (sfr_wr_i) begin
			if (sel_us) us_div_r <= sfr_wdata_i[stw_pkg::US_DIV_W-1:0];
			if (sel_ml) ms_lo_r <= sfr_wdata_i;
			if (sel_mh) ms_hi_r <= sfr_wdata_i;
			if (sel_hm) hms_div_r <= sfr_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// prescaler chain
	wire logic tmr_on = !system_timer_power_down_i;
	wire logic [15:0] ms_div = {ms_hi_r, ms_lo_r};

	// us tick is exported for the flash write timer
	stw_divider #(.W(stw_pkg::US_DIV_W)) u_us (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(tmr_on),
		.div_i(us_div_r),
		.tick_o(us_tick_o)
	);

	// ms tick is exported for the flash erase timer
	stw_divider #(.W(16)) u_ms (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(tmr_on),
		.div_i(ms_div),
		.tick_o(ms_tick_o)
	);

	stw_divider #(.W(8)) u_hms (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(ms_tick_o),
		.div_i(hms_div_r),
		.tick_o(hms_tick_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// milliseconds interrupt counter
	logic [CW-1:0] ms_reload_r;
	logic [CW-1:0] ms_cnt_r;
	logic ms_flag_r;
	wire logic ms_expire = ms_tick_o && (ms_cnt_r == '0);
	wire logic load_now = wr_ms && sfr_wdata_i[stw_pkg::LOAD_SEL_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ms_reload_r <= stw_pkg::RST_MS_INT[CW-1:0];
			ms_cnt_r <= stw_pkg::RST_MS_INT[CW-1:0];
		end else begin
			if (wr_ms) ms_reload_r <= sfr_wdata_i[CW-1:0];
			if (load_now) begin
				ms_cnt_r <= sfr_wdata_i[CW-1:0];
			end else if (ms_expire) begin
				ms_cnt_r <= ms_reload_r;
			end else if (ms_tick_o) begin
				ms_cnt_r <= ms_cnt_r - CW'(1);
			end
		end
	end

	// a read in the same cycle as a new expiry keeps the flag set
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ms_flag_r <= 1'b0;
		end else if (ms_expire) begin
			ms_flag_r <= 1'b1;
		end else if (rd_ms) begin
			ms_flag_r <= 1'b0;
		end
	end
	assign ms_int_o = ms_flag_r;

	////////////////////////////////////////////////////////////////////////////
	// watchdog
	logic [2:0] wd_bits_r;
	logic wd_on_r;
	logic wd_off_r;
	logic [WW-1:0] wd_cnt_cfg_r;
	logic [WW:0] wd_cnt_r;
	logic wd_exp_r;
	wire logic wd_pwr = !watchdog_power_down_i;
	wire logic en_fall = wr_wd && wd_bits_r[2]
		&& !sfr_wdata_i[stw_pkg::WD_EN_BIT];
	wire logic dis_fall = wr_wd && wd_bits_r[1]
		&& !sfr_wdata_i[stw_pkg::WD_DIS_BIT];
	wire logic rst_fall = wr_wd && wd_bits_r[0]
		&& !sfr_wdata_i[stw_pkg::WD_RST_BIT];
	wire logic wd_run = wd_on_r && wd_pwr;
	wire logic wd_hit = wd_run && hms_tick_o
		&& (wd_cnt_r == {1'b0, wd_cnt_cfg_r} + (WW+1)'(1));

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			wd_bits_r <= '0;
			wd_cnt_cfg_r <= stw_pkg::RST_WD_PERIOD;
			wd_on_r <= 1'b0;
			wd_off_r <= 1'b0;
		end else begin
			if (wr_wd) begin
				wd_bits_r <= sfr_wdata_i[stw_pkg::WD_EN_BIT:stw_pkg::WD_RST_BIT];
				wd_cnt_cfg_r <= sfr_wdata_i[WW-1:0];
			end
			if (dis_fall) begin
				wd_on_r <= 1'b0;
				wd_off_r <= 1'b1;
			end else if (en_fall) begin
				wd_on_r <= 1'b1;
				wd_off_r <= 1'b0;
			end
		end
	end

	// the free-running 100 ms phase gives the one-count uncertainty
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			wd_cnt_r <= '0;
			wd_exp_r <= 1'b0;
		end else begin
			wd_exp_r <= wd_hit;
			if (rst_fall || en_fall || !wd_run || wd_hit) begin
				wd_cnt_r <= '0;
			end else if (hms_tick_o) begin
				wd_cnt_r <= wd_cnt_r + (WW+1)'(1);
			end
		end
	end
	assign watchdog_expired_o = wd_exp_r;

	////////////////////////////////////////////////////////////////////////////
	// read mux
	logic [7:0] rdata_r;
	wire logic [7:0] wd_rd = {wd_on_r, wd_off_r, wd_bits_r[0], wd_cnt_cfg_r};
	wire logic [7:0] mux_rd =
		sel_ms ? {1'b0, ms_cnt_r} :
		sel_us ? {3'b000, us_div_r} :
		sel_ml ? ms_lo_r :
		sel_mh ? ms_hi_r :
		sel_hm ? hms_div_r :
		sel_wd ? wd_rd : 8'h0000;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_r <= '0;
		end else if (sfr_rd_i) begin
			rdata_r <= mux_rd;
		end
	end
	assign sfr_rdata_o = rdata_r;
	assign sfr_sel_o = sel_ms | sel_us | sel_ml | sel_mh | sel_hm | sel_wd;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ms_wr_imm;
		wr_ms && sfr_wdata_i[stw_pkg::LOAD_SEL_BIT];
	endsequence

	property p_load_now;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_ms_wr_imm |=> ms_cnt_r == $past(sfr_wdata_i[CW-1:0]);
	endproperty
	a_load_now: assert property (p_load_now)
		else $error("immediate load did not take");

	property p_rd_zero;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rd_ms |=> !sfr_rdata_o[stw_pkg::LOAD_SEL_BIT];
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("load select read back nonzero");

	property p_flag_clr;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rd_ms && !ms_expire |=> !ms_int_o;
	endproperty
	a_flag_clr: assert property (p_flag_clr)
		else $error("read did not clear ms flag");

	property p_flag_set;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		ms_expire && !load_now
		|=> ms_int_o && ms_cnt_r == $past(ms_reload_r);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("expiry did not set flag and reload");

	property p_delay_hold;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		wr_ms && !sfr_wdata_i[stw_pkg::LOAD_SEL_BIT] && !ms_tick_o
		|=> ms_cnt_r == $past(ms_cnt_r);
	endproperty
	a_delay_hold: assert property (p_delay_hold)
		else $error("delayed write changed the counter");

	property p_wd_pulse;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		watchdog_expired_o |=> !watchdog_expired_o;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse)
		else $error("watchdog event longer than one cycle");

	property p_wd_off;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		dis_fall |=> !wd_on_r ##1 !watchdog_expired_o;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("disable sequence left watchdog running");

	property p_wd_on;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		en_fall && !dis_fall |=> wd_on_r && wd_cnt_r == '0;
	endproperty
	a_wd_on: assert property (p_wd_on)
		else $error("enable sequence failed");

	property p_wd_restart;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rst_fall |=> wd_cnt_r == '0;
	endproperty
	a_wd_restart: assert property (p_wd_restart)
		else $error("restart sequence did not clear counter");

	property p_pd;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		system_timer_power_down_i |-> !us_tick_o && !ms_tick_o;
	endproperty
	a_pd: assert property (p_pd)
		else $error("tick while system timer powered down");
endmodule : stw_timer

// *** inc/stw_pkg.sv ***
package stw_pkg;
	// register offsets on the special function register bus
	localparam logic [7:0] ADDR_MS_INT = 8'h00fa;
	localparam logic [7:0] ADDR_US_DIV = 8'h00fb;
	localparam logic [7:0] ADDR_MS_DIV_LO = 8'h00fc;
	localparam logic [7:0] ADDR_MS_DIV_HI = 8'h00fd;
	localparam logic [7:0] ADDR_HMS_DIV = 8'h00fe;
	localparam logic [7:0] ADDR_WDT = 8'h00ff;
	// reset values
	localparam logic [7:0] RST_MS_INT = 8'h007f;
	localparam logic [4:0] RST_US_DIV = 5'h0003;
	localparam logic [7:0] RST_MS_DIV_LO = 8'h009f;
	localparam logic [7:0] RST_MS_DIV_HI = 8'h000f;
	localparam logic [7:0] RST_HMS_DIV = 8'h0063;
	localparam logic [4:0] RST_WD_PERIOD = 5'h0000;
	// field positions and widths
	localparam int LOAD_SEL_BIT = 7;
	localparam int WD_EN_BIT = 7;
	localparam int WD_DIS_BIT = 6;
	localparam int WD_RST_BIT = 5;
	localparam int MS_CNT_W = 7;
	localparam int US_DIV_W = 5;
	localparam int WD_PERIOD_W = 5;
endpackage : stw_pkg

// *** verification/tb.sv ***
`timescale 1ns/10ps
module tb;
	// design inputs, all but the clock driven at the falling edge
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h0000;
	logic sfr_wr_i = 1'b0;
	logic sfr_rd_i = 1'b0;
	logic [7:0] sfr_wdata_i = 8'h0000;
	logic watchdog_power_down_i = 1'b0;
	logic system_timer_power_down_i = 1'b0;
	// design outputs
	logic [7:0] sfr_rdata_o;
	logic sfr_sel_o;
	logic us_tick_o;
	logic ms_tick_o;
	logic hms_tick_o;
	logic ms_int_o;
	logic watchdog_expired_o;
	int err_count = 0;
	int cmp_count = 0;
	int wd_cnt = 0;
	int us_cnt = 0;
	int n;
	int m;
	logic [7:0] d;
	logic [7:0] rv [6] = '{8'h007f, 8'h0003, 8'h009f, 8'h000f, 8'h0063,
		8'h0000};

	stw_timer dut_u (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o),
		.sfr_sel_o(sfr_sel_o),
		.watchdog_power_down_i(watchdog_power_down_i),
		.system_timer_power_down_i(system_timer_power_down_i),
		.us_tick_o(us_tick_o),
		.ms_tick_o(ms_tick_o),
		.hms_tick_o(hms_tick_o),
		.ms_int_o(ms_int_o),
		.watchdog_expired_o(watchdog_expired_o)
	);

	always #2.5 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		if (watchdog_expired_o === 1'b1)
			wd_cnt <= wd_cnt + 1;
		if (us_tick_o === 1'b1)
			us_cnt <= us_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task print_verdict;
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// one strobe per access; a full cycle passes before the next one
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys_i);
		sfr_addr_i = a;
		sfr_wdata_i = v;
		sfr_wr_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_wr_i = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_sys_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_rd_i = 1'b0;
		v = sfr_rdata_o;
	endtask : rd

	function automatic logic sig(input int i);
		case (i)
			0: return us_tick_o;
			1: return ms_tick_o;
			2: return hms_tick_o;
			3: return ms_int_o;
			default: return watchdog_expired_o;
		endcase
	endfunction : sig

	// counts falling edges until the chosen output is seen high
	task wait_hi(input int i, output int k);
		k = 0;
		do begin
			@(negedge clk_sys_i);
			k++;
		end while (sig(i) !== 1'b1 && k < 2000);
	endtask : wait_hi

	task gap(input int i, output int k);
		wait_hi(i, k);
		wait_hi(i, k);
	endtask : gap

	// called while the flag is high: read clears it, then time the next
	task gap_int(output int k);
		rd(8'h00fa, d);
		chk(16'(d[7]), 16'h0000);
		chk(16'(ms_int_o), 16'h0000);
		wait_hi(3, k);
		k = k + 2;
	endtask : gap_int

	task chk_regs;
		for (int i = 0; i < 6; i++) begin
			rd(8'(8'h00fa + i), d);
			chk(16'(d), 16'(rv[i]));
			chk(16'(sfr_sel_o), 16'h0001);
		end
	endtask : chk_regs

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(negedge clk_sys_i);
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (5) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk_regs();
		rd(8'h0010, d);
		chk(16'(d), 16'h0000);
		chk(16'(sfr_sel_o), 16'h0000);
		gap(0, n);
		chk(16'(n), 16'h0004);
		// high byte weighs 256
		wr(8'h00fd, 8'h0001);
		wr(8'h00fc, 8'h0000);
		gap(1, n);
		gap(1, n);
		chk(16'(n), 16'h0101);
		wr(8'h00fc, 8'h0003);
		wr(8'h00fd, 8'h0000);
		wr(8'h00fe, 8'h0001);
		wr(8'h00fb, 8'h00e2);
		rd(8'h00fb, d);
		chk(16'(d), 16'h0002);
		gap(0, n);
		chk(16'(n), 16'h0003);
		gap(1, n);
		gap(1, n);
		chk(16'(n), 16'h0004);
		gap(2, n);
		gap(2, n);
		chk(16'(n), 16'h0008);
		// immediate load: default 128-tick count must not linger
		wr(8'h00fa, 8'h0082);
		wait_hi(3, n);
		chk(16'(n <= 13), 16'h0001);
		gap_int(n);
		chk(16'(n), 16'h000c);
		// delayed load: the running period of 12 finishes first
		rd(8'h00fa, d);
		wr(8'h00fa, 8'h0005);
		wait_hi(3, n);
		chk(16'(n), 16'h0008);
		gap_int(n);
		chk(16'(n), 16'h0018);
		// watchdog, count 1, hundred-ms period of 8 clocks
		wr(8'h00ff, 8'h0081);
		wr(8'h00ff, 8'h0001);
		rd(8'h00ff, d);
		chk(16'(d), 16'h0081);
		wait_hi(4, n);
		chk(16'(n >= 15 && n <= 26), 16'h0001);
		@(negedge clk_sys_i);
		chk(16'(watchdog_expired_o), 16'h0000);
		m = wd_cnt;
		wr(8'h00ff, 8'h0021);
		rd(8'h00ff, d);
		chk(16'(d), 16'h00a1);
		repeat (6) begin
			wr(8'h00ff, 8'h0021);
			wr(8'h00ff, 8'h0001);
			repeat (4) @(negedge clk_sys_i);
		end
		chk(16'(wd_cnt - m), 16'h0000);
		wr(8'h00ff, 8'h0041);
		wr(8'h00ff, 8'h0001);
		rd(8'h00ff, d);
		chk(16'(d), 16'h0041);
		m = wd_cnt;
		repeat (60) @(negedge clk_sys_i);
		chk(16'(wd_cnt - m), 16'h0000);
		// power-down gates both timers
		wr(8'h00ff, 8'h0081);
		wr(8'h00ff, 8'h0001);
		watchdog_power_down_i = 1'b1;
		m = wd_cnt;
		repeat (60) @(negedge clk_sys_i);
		chk(16'(wd_cnt - m), 16'h0000);
		watchdog_power_down_i = 1'b0;
		system_timer_power_down_i = 1'b1;
		m = us_cnt;
		repeat (30) @(negedge clk_sys_i);
		chk(16'(us_cnt - m), 16'h0000);
		system_timer_power_down_i = 1'b0;
		gap(0, n);
		chk(16'(n), 16'h0003);
		// mid-run reset: written values, pending flag and watchdog all drop
		rstn_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk(16'(ms_int_o), 16'h0000);
		chk(16'(watchdog_expired_o), 16'h0000);
		chk_regs();
		print_verdict();
	end
endmodule : tb
